//--- hw/vef_pkg.sv
package vef_pkg;

	// register addresses (5-bit address space of the host ports)
	localparam int ADR_W = 5;
	localparam logic [4:0] ADR_FSA = 5'h00;
	localparam logic [4:0] ADR_FSB = 5'h01;
	localparam logic [4:0] ADR_FSC = 5'h02;
	localparam logic [4:0] ADR_CC0 = 5'h03;
	localparam logic [4:0] ADR_CC1 = 5'h04;
	localparam logic [4:0] ADR_CC2 = 5'h05;
	localparam logic [4:0] ADR_CC3 = 5'h06;
	localparam logic [4:0] ADR_ID_LO = 5'h09;
	localparam logic [4:0] ADR_ID_HI = 5'h0a;

	// reset values
	localparam logic [7:0] FSA_RST = 8'hfd;
	localparam logic [7:0] FSB_RST = 8'h03;
	localparam logic [7:0] FSC_RST = 8'h00;
	localparam logic [7:0] CC_RST = 8'h00;

	// encoder_function_select_a fields
	localparam int FSA_ENC = 0;
	localparam int FSA_SETUP = 2;
	localparam int FSA_BURST = 3;
	localparam int FSA_YC = 4;
	localparam int FSA_PIXEN = 5;
	localparam int FSA_MASK = 6;
	localparam int FSA_FIDPOL = 7;
	// encoder_function_select_b fields
	localparam int FSB_DAC_LC = 0;
	localparam int FSB_DAC_COMP = 1;
	localparam int FSB_PIXFMT = 4;
	// encoder_function_select_c fields
	localparam int FSC_CC_F1 = 0;
	localparam int FSC_CC_F2 = 1;

	// two-wire slave address 1,0,0,0,1,s,0
	localparam logic [4:0] SLV_ADDR_HI = 5'h11;
	localparam logic SLV_ADDR_LSB = 1'b0;
	localparam logic [6:0] GEN_CALL = 7'h00;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT = 4'h7;

	// three-wire command byte
	localparam int CMD_WR_BIT = 7;

	// pixel levels
	localparam logic [7:0] BLANK_Y = 8'h10;
	localparam logic [7:0] BLANK_C = 8'h80;
	localparam logic [7:0] CLAMP_LO = 8'h10;
	localparam logic [7:0] CLAMP_HI = 8'heb;

	// timing
	localparam int PIX_DIV_DOC = 2;
	localparam logic [9:0] CC_LINE_F1 = 10'd21;
	localparam logic [9:0] CC_LINE_F2 = 10'd284;

	// two-wire slave states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WR = 3'b011,
		ST_WR_ACK = 3'b100,
		ST_RD = 3'b101,
		ST_RD_ACK = 3'b110
	} vef_i2c_st_t;

endpackage : vef_pkg

//--- hw/vef_frontend.sv
// What this block does
// - select_b bit 4 picks pixel bus format
// - 8-bit: low byte captured every clock
// - 16-bit: Y low, CbCr high, pixel clock
// - pixel clock divided from system clock
// - select pin picks three-wire or two-wire port
// - two-wire slave, 7-bit address, fast mode
// - slave address 1000 1s0, rw ignored
// - write: first byte address, then autoincrement
// - read: starts at 09H, only 09H/0AH
// - general call never acknowledged
// - three-wire samples input while select low
// - first byte: direction and start address
// - write direction stores following bytes
// - read direction shifts registers out
// - vsync reset holds field set by input
// - captions on lines 21/284 with parity
// - caption registers double-buffered at vsync
// - select_a standard, setup, burst, default one
// - pixel enable low forces blanking level
// - vblank mask blanks and clamps 16..235
// - field output polarity selectable, default one
// - two-bit output activity select
// - two-bit caption mode select
module vef_frontend #(
	parameter int PIX_DIV = vef_pkg::PIX_DIV_DOC,
	parameter int LINE_PIX = 858,
	parameter int FRAME_LINES = 525,
	parameter int FIELD1_LINES = 262,
	parameter int VBLANK_LINES = 20,
	parameter logic [7:0] ID_LO_VAL = 8'h5a, // arbitrary value
	parameter logic [7:0] ID_HI_VAL = 8'h01  // arbitrary value
) (
	// clock, reset, enable
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clkEn,
	// pixel input
	input wire logic [15:0] pixelBus,
	output logic pixelClockOut,
	output logic [7:0] pixY,
	output logic [7:0] pixC,
	output logic pixValid,
	// host port select; chipSelectN doubles as the address select pin
	input wire logic ifaceSelect,
	input wire logic chipSelectN,
	// three-wire port
	input wire logic serialClock,
	input wire logic serialIn,
	output logic serialOut,
	output logic serialOutEn,
	// two-wire port
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// external sync
	input wire logic vsyncResetN,
	input wire logic fieldIdIn,
	output logic fieldIdOut,
	output logic vsyncOut,
	output logic vblankOut,
	// captions
	output logic [15:0] captionWord,
	output logic captionActive,
	// encoder controls
	output logic encStandard,
	output logic setupEnable,
	output logic burstEnable,
	output logic ycSelect,
	output logic lumaChromaOn,
	output logic compositeOn
);

	localparam int HALF = PIX_DIV / 2;

	typedef struct packed {
		logic scl1, scl2, sclP, sda1, sda2, sdaP;
		logic sel1, sel2, ifs1, ifs2;
		logic vr1, vr2, fi1, fi2;
		logic wt1, wt2, wt3;
		logic [15:0] pix1;
		logic [15:0] pix2;
		logic [7:0] fsa;
		logic [7:0] fsb;
		logic [7:0] fsc;
		logic [3:0][7:0] cc;
		logic [3:0][7:0] ccw;
		vef_pkg::vef_i2c_st_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic rw;
		logic first;
		logic sdaLow;
		logic [4:0] addr;
		logic [3:0] pxDiv;
		logic pxClk;
		logic [7:0] yOut;
		logic [7:0] cOut;
		logic pv;
		logic [9:0] hCnt;
		logic [9:0] lineCnt;
		logic field_id_out;
		logic vs;
		logic vb;
		logic [15:0] ccWord;
		logic ccOn;
	} vef_core_t;

	typedef struct packed {
		logic [2:0] cnt;
		logic [7:0] sh;
		logic cmd;
		logic wr;
		logic [4:0] addr;
		logic [7:0] out;
	} vef_link_t;

	vef_core_t q, d;
	vef_link_t lq, ld;
	logic wrTgl;
	logic [4:0] wrAddr;
	logic [7:0] wrData;

	// register read mux, shared by both host ports
	function automatic logic [7:0] rdReg(input logic [4:0] a,
		input vef_core_t s);
		logic [7:0] r;
		r = 8'h00;
		unique case (a)
			vef_pkg::ADR_FSA: r = s.fsa;
			vef_pkg::ADR_FSB: r = s.fsb;
			vef_pkg::ADR_FSC: r = s.fsc;
			vef_pkg::ADR_CC0: r = s.cc[0];
			vef_pkg::ADR_CC1: r = s.cc[1];
			vef_pkg::ADR_CC2: r = s.cc[2];
			vef_pkg::ADR_CC3: r = s.cc[3];
			vef_pkg::ADR_ID_LO: r = ID_LO_VAL;
			vef_pkg::ADR_ID_HI: r = ID_HI_VAL;
			default: r = 8'h00;
		endcase
		return r;
	endfunction : rdReg

	// register write; id and unmapped addresses ignore writes
	function automatic vef_core_t wrReg(input vef_core_t s,
		input logic [4:0] a, input logic [7:0] v);
		vef_core_t r;
		r = s;
		unique case (a)
			vef_pkg::ADR_FSA: r.fsa = v;
			vef_pkg::ADR_FSB: r.fsb = v;
			vef_pkg::ADR_FSC: r.fsc = v;
			vef_pkg::ADR_CC0: r.cc[0] = v;
			vef_pkg::ADR_CC1: r.cc[1] = v;
			vef_pkg::ADR_CC2: r.cc[2] = v;
			vef_pkg::ADR_CC3: r.cc[3] = v;
			default: r = s;
		endcase
		return r;
	endfunction : wrReg

	// caption byte with odd parity in bit 7
	function automatic logic [7:0] ccPar(input logic [7:0] c);
		return {~^c[6:0], c[6:0]};
	endfunction : ccPar

	// blank, mask and clamp one pixel byte
	function automatic logic [7:0] pixFix(input logic [7:0] v,
		input logic [7:0] blank, input vef_core_t s, input logic vb);
		logic [7:0] r;
		r = v;
		if (!s.fsa[vef_pkg::FSA_PIXEN]) begin
			r = blank;
		end else if (s.fsa[vef_pkg::FSA_MASK]) begin
			if (vb) begin
				r = blank;
			end else if (v < vef_pkg::CLAMP_LO) begin
				r = vef_pkg::CLAMP_LO;
			end else if (v > vef_pkg::CLAMP_HI) begin
				r = vef_pkg::CLAMP_HI;
			end
		end
		return r;
	endfunction : pixFix

	// decoded events of the core domain
	logic i2cMode, sclRise, sclFall, startC, stopC, addrHit, wrTake;
	logic pxTick, pxRise, fmt16, isF1, inVb, fieldStart;
	logic [9:0] lineInField;
	assign i2cMode = !q.ifs2;
	assign sclRise = q.scl2 && !q.sclP;
	assign sclFall = !q.scl2 && q.sclP;
	assign startC = q.scl2 && q.sclP && q.sdaP && !q.sda2;
	assign stopC = q.scl2 && q.sclP && !q.sdaP && q.sda2;
	// rw bit excluded from the match; general call never matches
	assign addrHit = (q.sh[7:3] == vef_pkg::SLV_ADDR_HI)
		&& (q.sh[2] == q.sel2) && (q.sh[1] == vef_pkg::SLV_ADDR_LSB)
		&& (q.sh[7:1] != vef_pkg::GEN_CALL);
	assign wrTake = (q.wt2 ^ q.wt3) && q.ifs2;
	assign pxTick = (q.pxDiv == 4'(HALF - 1));
	assign pxRise = pxTick && !q.pxClk;
	assign fmt16 = q.fsb[vef_pkg::FSB_PIXFMT];
	assign isF1 = (q.lineCnt <= 10'(FIELD1_LINES));
	assign lineInField = isF1 ? q.lineCnt : q.lineCnt - 10'(FIELD1_LINES);
	assign inVb = (lineInField <= 10'(VBLANK_LINES));
	assign fieldStart = pxRise && q.vr2 && (q.hCnt == 10'(LINE_PIX - 1))
		&& (q.lineCnt == 10'(FRAME_LINES) || q.lineCnt == 10'(FIELD1_LINES));

	// core next state; everything freezes while clkEn is low
	always_comb begin
		d = q;
		if (clkEn) begin
			d.scl1 = sclIn;
			d.scl2 = q.scl1;
			d.sclP = q.scl2;
			d.sda1 = sdaIn;
			d.sda2 = q.sda1;
			d.sdaP = q.sda2;
			d.sel1 = chipSelectN;
			d.sel2 = q.sel1;
			d.ifs1 = ifaceSelect;
			d.ifs2 = q.ifs1;
			d.vr1 = vsyncResetN;
			d.vr2 = q.vr1;
			d.fi1 = fieldIdIn;
			d.fi2 = q.fi1;
			d.wt1 = wrTgl;
			d.wt2 = q.wt1;
			d.wt3 = q.wt2;
			d.pix1 = pixelBus;
			d.pix2 = q.pix1;
			// three-wire writes arrive as toggles; address and data stable
			if (wrTake) begin
				d = wrReg(d, wrAddr, wrData);
			end
			// two-wire slave, oversampled: fast mode is far below core rate
			if (!i2cMode) begin
				d.st = vef_pkg::ST_IDLE;
				d.sdaLow = 1'b0;
			end else if (startC) begin
				d.st = vef_pkg::ST_ADDR;
				d.cnt = 4'h0;
				d.first = 1'b1;
				d.sdaLow = 1'b0;
			end else if (stopC) begin
				d.st = vef_pkg::ST_IDLE;
				d.sdaLow = 1'b0;
			end else begin
				unique case (q.st)
					vef_pkg::ST_IDLE: begin
						d.sdaLow = 1'b0;
					end
					vef_pkg::ST_ADDR, vef_pkg::ST_WR: begin
						if (sclRise && q.cnt < vef_pkg::BYTE_BITS) begin
							d.sh = {q.sh[6:0], q.sda2};
							d.cnt = q.cnt + 4'h1;
						end
						if (sclFall && q.cnt == vef_pkg::BYTE_BITS) begin
							d.cnt = 4'h0;
							if (q.st == vef_pkg::ST_ADDR) begin
								if (addrHit) begin
									d.st = vef_pkg::ST_ADDR_ACK;
									d.sdaLow = 1'b1;
									d.rw = q.sh[0];
								end else begin
									d.st = vef_pkg::ST_IDLE;
								end
							end else begin
								d.st = vef_pkg::ST_WR_ACK;
								d.sdaLow = 1'b1;
								if (q.first) begin
									d.addr = q.sh[4:0];
									d.first = 1'b0;
								end else begin
									d = wrReg(d, q.addr, q.sh);
									d.addr = q.addr + 5'h01;
								end
							end
						end
					end
					vef_pkg::ST_ADDR_ACK, vef_pkg::ST_WR_ACK: begin
						if (sclFall) begin
							d.cnt = 4'h0;
							if (q.st == vef_pkg::ST_ADDR_ACK && q.rw) begin
								// read always restarts at the low id byte
								d.st = vef_pkg::ST_RD;
								d.sh = rdReg(vef_pkg::ADR_ID_LO, q);
								d.sdaLow = !d.sh[7];
								d.addr = vef_pkg::ADR_ID_HI;
							end else begin
								d.st = vef_pkg::ST_WR;
								d.sdaLow = 1'b0;
							end
						end
					end
					vef_pkg::ST_RD: begin
						if (sclFall) begin
							if (q.cnt == vef_pkg::LAST_BIT) begin
								d.st = vef_pkg::ST_RD_ACK;
								d.sdaLow = 1'b0;
								d.cnt = 4'h0;
							end else begin
								d.sh = {q.sh[6:0], 1'b0};
								d.sdaLow = !q.sh[6];
								d.cnt = q.cnt + 4'h1;
							end
						end
					end
					vef_pkg::ST_RD_ACK: begin
						if (sclRise && q.sda2) begin
							d.st = vef_pkg::ST_IDLE; // master nack ends read
						end else if (sclFall) begin
							// only the two id bytes cycle, never the rest
							d.st = vef_pkg::ST_RD;
							d.sh = rdReg(q.addr, q);
							d.sdaLow = !d.sh[7];
							d.addr = (q.addr == vef_pkg::ADR_ID_HI) ?
								vef_pkg::ADR_ID_LO : vef_pkg::ADR_ID_HI;
						end
					end
					default: begin
						d.st = vef_pkg::ST_IDLE;
					end
				endcase
			end
			// pixel clock divider
			d.pxDiv = pxTick ? 4'h0 : q.pxDiv + 4'h1;
			if (pxTick) begin
				d.pxClk = !q.pxClk;
			end
			// capture: every clock in 8-bit, pixel clock rise in 16-bit
			d.pv = 1'b0;
			if (!fmt16 || pxRise) begin
				d.pv = 1'b1;
				d.yOut = pixFix(q.pix2[7:0], vef_pkg::BLANK_Y, q, inVb);
				d.cOut = fmt16 ?
					pixFix(q.pix2[15:8], vef_pkg::BLANK_C, q, inVb) :
					vef_pkg::BLANK_C;
			end
			// sync generator at pixel rate, held while vsync reset low
			d.vs = 1'b0;
			if (pxRise && !q.vr2) begin
				d.hCnt = 10'h000;
				d.lineCnt = q.fi2 ? 10'h001 : 10'(FIELD1_LINES + 1);
				d.ccw = q.cc;
			end else if (pxRise) begin
				if (q.hCnt == 10'(LINE_PIX - 1)) begin
					d.hCnt = 10'h000;
					d.lineCnt = (q.lineCnt == 10'(FRAME_LINES)) ?
						10'h001 : q.lineCnt + 10'h001;
				end else begin
					d.hCnt = q.hCnt + 10'h001;
				end
			end
			// working caption copies follow the host copies at vsync and while vsync reset is held low
			if (fieldStart) begin
				d.vs = 1'b1;
				d.ccw = q.cc;
			end
			d.field_id_out = isF1 ^ q.fsa[vef_pkg::FSA_FIDPOL];
			d.vb = inVb;
			// caption line selection per mode
			d.ccOn = 1'b0;
			d.ccWord = 16'h0000;
			if (q.lineCnt == vef_pkg::CC_LINE_F1 &&
				q.fsc[vef_pkg::FSC_CC_F1]) begin
				d.ccOn = 1'b1;
				d.ccWord = {ccPar(q.ccw[1]), ccPar(q.ccw[0])};
			end else if (q.lineCnt == vef_pkg::CC_LINE_F2 &&
				q.fsc[vef_pkg::FSC_CC_F2]) begin
				d.ccOn = 1'b1;
				d.ccWord = {ccPar(q.ccw[3]), ccPar(q.ccw[2])};
			end
		end
	end

	// core registers, synchronous reset to defaults
	always_ff @(posedge core_clk) begin
		if (reset) begin
			q <= '0;
			q.fsa <= vef_pkg::FSA_RST;
			q.fsb <= vef_pkg::FSB_RST;
			q.fsc <= vef_pkg::FSC_RST;
			q.cc <= {4{vef_pkg::CC_RST}};
			q.ccw <= {4{vef_pkg::CC_RST}};
			q.vr2 <= 1'b1;
			q.vr1 <= 1'b1;
			q.lineCnt <= 10'h001;
		end else begin
			q <= d;
		end
	end

	// three-wire link on its own clock; the register bank read here only
	// changes after writes this same link issued earlier, so it is static
	// by the time a later byte reads it
	always_comb begin
		logic [7:0] b;
		b = {lq.sh[6:0], serialIn};
		ld = lq;
		ld.sh = b;
		ld.cnt = lq.cnt + 3'h1;
		ld.out = {lq.out[6:0], 1'b0};
		if (lq.cnt == 3'h7) begin
			if (!lq.cmd) begin
				ld.cmd = 1'b1;
				ld.wr = b[vef_pkg::CMD_WR_BIT];
				ld.addr = b[4:0];
				if (!b[vef_pkg::CMD_WR_BIT]) begin
					ld.out = rdReg(b[4:0], q);
					ld.addr = b[4:0] + 5'h01;
				end
			end else if (lq.wr) begin
				ld.addr = lq.addr + 5'h01;
			end else begin
				ld.out = rdReg(lq.addr, q);
				ld.addr = lq.addr + 5'h01;
			end
		end
	end

	// chip select high ends the frame and clears the link state
	always_ff @(posedge serialClock or posedge chipSelectN) begin
		if (chipSelectN) begin
			lq <= '0;
		end else begin
			lq <= ld;
		end
	end

	// write hand-off: toggle plus held address and data
	always_ff @(posedge serialClock or posedge reset) begin
		if (reset) begin
			wrTgl <= 1'b0;
			wrAddr <= 5'h00;
			wrData <= 8'h00;
		end else if (!chipSelectN && lq.cmd && lq.wr && lq.cnt == 3'h7) begin
			wrTgl <= !wrTgl;
			wrAddr <= lq.addr;
			wrData <= {lq.sh[6:0], serialIn};
		end
	end

	// outputs
	assign pixelClockOut = q.pxClk;
	assign pixY = q.yOut;
	assign pixC = q.cOut;
	assign pixValid = q.pv;
	assign serialOut = lq.out[7];
	assign serialOutEn = q.ifs2;
	assign sdaOut = 1'b0;
	assign sdaOe = q.sdaLow;
	assign fieldIdOut = q.field_id_out;
	assign vsyncOut = q.vs;
	assign vblankOut = q.vb;
	assign captionWord = q.ccWord;
	assign captionActive = q.ccOn;
	assign encStandard = q.fsa[vef_pkg::FSA_ENC];
	assign setupEnable = q.fsa[vef_pkg::FSA_SETUP];
	assign burstEnable = q.fsa[vef_pkg::FSA_BURST];
	assign ycSelect = q.fsa[vef_pkg::FSA_YC];
	assign lumaChromaOn = q.fsb[vef_pkg::FSB_DAC_LC];
	assign compositeOn = q.fsb[vef_pkg::FSB_DAC_COMP];

	// checks on the core domain
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// judged from the pin two edges back, so a broken sync chain shows
	a_so_tristate: assert property (($past(clkEn) && $past(clkEn, 2)
		&& !$past(ifaceSelect, 2)) |-> !serialOutEn)
		else $error("serial out driven in two-wire mode");
	a_addr_nack: assert property ((clkEn && i2cMode && !startC && !stopC
		&& q.st == vef_pkg::ST_ADDR && sclFall && q.cnt == 4'h8
		&& q.sh[7:1] == vef_pkg::GEN_CALL) |=> !sdaOe)
		else $error("general call acknowledged");
	a_addr_ack: assert property ((clkEn && i2cMode && !startC && !stopC
		&& q.st == vef_pkg::ST_ADDR && sclFall && q.cnt == 4'h8 && addrHit)
		|=> (sdaOe && q.st == vef_pkg::ST_ADDR_ACK))
		else $error("own address not acknowledged");
	a_read_start: assert property ((clkEn && i2cMode && !startC && !stopC
		&& q.st == vef_pkg::ST_ADDR_ACK && q.rw && sclFall)
		|=> (q.sh == ID_LO_VAL && q.addr == vef_pkg::ADR_ID_HI))
		else $error("read did not start at id low");
	a_pixclk_div: assert property ((clkEn && pxTick)
		|=> (pixelClockOut != $past(pixelClockOut)))
		else $error("pixel clock failed to toggle");
	a_pix_blank: assert property ((clkEn && (!fmt16 || pxRise)
		&& !q.fsa[vef_pkg::FSA_PIXEN]) |=> (pixValid
		&& pixY == vef_pkg::BLANK_Y))
		else $error("disabled pixels not blanked");
	a_pix_clamp: assert property ((clkEn && (!fmt16 || pxRise)
		&& q.fsa[vef_pkg::FSA_MASK]) |=> (pixY >= vef_pkg::CLAMP_LO
		&& pixY <= vef_pkg::CLAMP_HI))
		else $error("pixel outside clamp range");
	a_vrst_hold: assert property ((clkEn && pxRise && !q.vr2 && q.fi2)
		|=> (q.lineCnt == 10'h001 && q.hCnt == 10'h000))
		else $error("vsync reset did not hold field one");
	a_cc_buffer: assert property ((clkEn && fieldStart)
		|=> (q.ccw == $past(q.cc) && vsyncOut))
		else $error("caption copy not taken at vsync");

endmodule : vef_frontend

//--- test/vef_host_model.sv
module vef_host_model (
	// three-wire port
	output logic serialClock,
	output logic chipSelectN,
	output logic serialIn,
	input wire logic serialOut,
	// two-wire port
	output logic scl,
	output logic sdaDrv,
	input wire logic sdaLine
);
	timeunit 1ns;
	timeprecision 1ns;

	// quarter of one two-wire bit at 400 kbit/s
	localparam int Q = 625;

	// idle levels: link clock stands still, bus released
	initial begin
		serialClock = 1'b0;
		chipSelectN = 1'b1;
		serialIn = 1'b0;
		scl = 1'b1;
		sdaDrv = 1'b1;
	end

	// command byte, then n data bytes; read bits taken before each rise
	task automatic frame(input logic [7:0] cmd, input logic [31:0] wr,
		input int n, output logic [31:0] rd);
		logic [39:0] sh;
		int i;
		sh = {cmd, wr};
		rd = 32'h0;
		chipSelectN = 1'b0;
		#160;
		for (i = 0; i < 8 * (n + 1); i++) begin
			// in read direction input is ignored, so keep it wiggling
			serialIn = (cmd[7] || i < 8) ? sh[39 - i] : ~serialIn;
			#16;
			if (i >= 8)
				rd = {rd[30:0], serialOut};
			serialClock = 1'b1;
			#16;
			serialClock = 1'b0;
		end
		#160;
		chipSelectN = 1'b1;
		serialIn = ~serialIn;
		#200;
	endtask : frame

	// start condition: data falls while clock high
	task automatic i2cStart;
		sdaDrv = 1'b1;
		scl = 1'b1;
		#Q;
		sdaDrv = 1'b0;
		#Q;
		scl = 1'b0;
		#Q;
	endtask : i2cStart

	// stop condition: data rises while clock high
	task automatic i2cStop;
		sdaDrv = 1'b0;
		#Q;
		scl = 1'b1;
		#Q;
		sdaDrv = 1'b1;
		#Q;
	endtask : i2cStop

	// eight bits out, msb first, then a released ack slot
	task automatic i2cByte(input logic [7:0] b, output logic [7:0] got,
		output logic ack);
		logic [8:0] sh;
		int i;
		sh = {b, 1'b1};
		got = 8'h00;
		ack = 1'b0;
		for (i = 0; i < 9; i++) begin
			sdaDrv = sh[8 - i];
			#Q;
			scl = 1'b1;
			#Q;
			if (i < 8)
				got[7 - i] = sdaLine;
			else
				ack = ~sdaLine;
			#Q;
			scl = 1'b0;
			#Q;
		end
	endtask : i2cByte
endmodule : vef_host_model

//--- test/video_encoder_control_frontend_tb_top.sv
module video_encoder_control_frontend_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [7:0] ID_LO = 8'h5a; // arbitrary value
	localparam logic [7:0] ID_HI = 8'h01; // arbitrary value

	logic core_clk, reset, ifaceSelect, saPin, vsyncResetN, fieldIdIn;
	logic [15:0] pixelBus, captionWord;
	logic serialClock, hostCsN, serialIn, serialOut, serialOutEn;
	logic scl, sdaDrv, sdaOut, sdaOe, pixelClockOut, pixValid;
	logic fieldIdOut, vsyncOut, vblankOut, captionActive;
	logic [7:0] pixY, pixC, got;
	logic encStandard, setupEnable, burstEnable, ycSelect;
	logic lumaChromaOn, compositeOn, ack;
	logic [31:0] rd;
	wire chipSelectN;
	wire sdaLine;
	int failures, compares, cycles, i, k;
	logic [4:0] adrTab [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
		5'h05, 5'h06, 5'h09, 5'h0a};
	logic [7:0] expTab [9] = '{vef_pkg::FSA_RST, vef_pkg::FSB_RST,
		vef_pkg::FSC_RST, vef_pkg::CC_RST, vef_pkg::CC_RST,
		vef_pkg::CC_RST, vef_pkg::CC_RST, ID_LO, ID_HI};

	// pin shared by chip select and slave address bit
	assign chipSelectN = ifaceSelect ? hostCsN : saPin;
	// open-drain data line with pull-up
	assign sdaLine = sdaDrv & (~sdaOe | sdaOut);

	// short lines, but enough of them to reach both caption lines
	vef_frontend #(.LINE_PIX(2), .FRAME_LINES(300), .FIELD1_LINES(150),
		.VBLANK_LINES(1), .ID_LO_VAL(ID_LO), .ID_HI_VAL(ID_HI))
	vef_frontend_i (
		.core_clk(core_clk), .reset(reset), .clkEn(1'b1),
		.pixelBus(pixelBus), .pixelClockOut(pixelClockOut),
		.pixY(pixY), .pixC(pixC), .pixValid(pixValid),
		.ifaceSelect(ifaceSelect), .chipSelectN(chipSelectN),
		.serialClock(serialClock), .serialIn(serialIn),
		.serialOut(serialOut), .serialOutEn(serialOutEn),
		.sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.vsyncResetN(vsyncResetN), .fieldIdIn(fieldIdIn),
		.fieldIdOut(fieldIdOut), .vsyncOut(vsyncOut),
		.vblankOut(vblankOut), .captionWord(captionWord),
		.captionActive(captionActive), .encStandard(encStandard),
		.setupEnable(setupEnable), .burstEnable(burstEnable),
		.ycSelect(ycSelect), .lumaChromaOn(lumaChromaOn),
		.compositeOn(compositeOn)
	);

	vef_host_model host_i (
		.serialClock(serialClock), .chipSelectN(hostCsN),
		.serialIn(serialIn), .serialOut(serialOut),
		.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine)
	);

	// core clock, 20 ns
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// hang guard, well above the expected run length
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			report_and_stop;
		end
	end

	task automatic report_and_stop;
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	task automatic wr3(input logic [4:0] a, input logic [7:0] d);
		host_i.frame({3'b100, a}, {d, 24'h0}, 1, rd);
	endtask : wr3

	task automatic rd3(input logic [4:0] a, output logic [7:0] d);
		host_i.frame({3'b000, a}, 32'h0, 1, rd);
		d = rd[7:0];
	endtask : rd3

	// settle after a register change, then stop on a fresh sample
	task automatic pixWait;
		cyc(11);
		for (k = 0; k < 50 && pixValid !== 1'b1; k++)
			@(negedge core_clk);
	endtask : pixWait

	initial begin
		reset = 1'b1;
		ifaceSelect = 1'b1;
		saPin = 1'b0;
		vsyncResetN = 1'b1;
		fieldIdIn = 1'b1;
		pixelBus = 16'hff40;
		failures = 0;
		compares = 0;
		cycles = 0;
		repeat (41) @(posedge core_clk);
		reset <= 1'b0;
		cyc(5);
		chk({encStandard, setupEnable, burstEnable, ycSelect}, 4'hf);
		chk({compositeOn, lumaChromaOn}, 2'b11);
		// every mapped register at its reset value
		for (i = 0; i < 9; i++) begin
			rd3(adrTab[i], got);
			chk(got, expTab[i]);
		end
		// one command, four bytes across the caption registers
		host_i.frame(8'h83, 32'h41424142, 4, rd);
		rd3(vef_pkg::ADR_CC1, got);
		chk(got, 8'h42);
		wr3(vef_pkg::ADR_ID_LO, 8'h00);
		rd3(vef_pkg::ADR_ID_LO, got);
		chk(got, ID_LO);
		rd3(5'h1f, got);
		chk(got, 8'h00);
		host_i.frame(8'h00, 32'h0, 2, rd);
		chk(rd[15:0], {vef_pkg::FSA_RST, vef_pkg::FSB_RST});
		// sync reset held: field from input, captions off
		@(posedge core_clk) vsyncResetN <= 1'b0;
		cyc(20);
		chk(fieldIdOut, 1'b0);
		chk({captionActive, captionWord}, 17'h00000);
		@(posedge core_clk) fieldIdIn <= 1'b0;
		cyc(20);
		chk(fieldIdOut, 1'b1);
		wr3(vef_pkg::ADR_FSA, 8'h7d);
		cyc(5);
		chk(fieldIdOut, 1'b0);
		@(posedge core_clk) vsyncResetN <= 1'b1;
		@(negedge core_clk);
		for (k = 0; k < 1000 && vsyncOut !== 1'b1; k++)
			@(negedge core_clk);
		cyc(2);
		chk(fieldIdOut, 1'b1);
		// caption line per mode, built from the working copies
		for (i = 1; i < 3; i++) begin
			wr3(vef_pkg::ADR_FSC, i[7:0]);
			for (k = 0; k < 1500 && captionActive !== 1'b1; k++)
				@(negedge core_clk);
			chk(captionWord, 16'hc2c1);
			chk(fieldIdOut, (i == 1));
		end
		// pixel path: 8-bit, 16-bit, clamp, disable
		wr3(vef_pkg::ADR_FSA, 8'hbd);
		pixWait;
		chk({pixC, pixY}, {vef_pkg::BLANK_C, 8'h40});
		wr3(vef_pkg::ADR_FSB, 8'h13);
		pixWait;
		chk({pixC, pixY}, 16'hff40);
		@(posedge core_clk) pixelBus <= 16'h05ff;
		wr3(vef_pkg::ADR_FSA, 8'hfd);
		k = 0;
		for (i = 0; i < 400 && !(k >= 6 && pixValid === 1'b1); i++) begin
			@(negedge core_clk);
			k = (vblankOut === 1'b0) ? k + 1 : 0;
		end
		chk({pixC, pixY}, {vef_pkg::CLAMP_LO, vef_pkg::CLAMP_HI});
		wr3(vef_pkg::ADR_FSA, 8'hdd);
		pixWait;
		chk({pixC, pixY}, {vef_pkg::BLANK_C, vef_pkg::BLANK_Y});
		got[0] = pixelClockOut;
		cyc(1);
		chk(pixelClockOut, !got[0]);
		// each output activity code
		for (i = 0; i < 4; i++) begin
			wr3(vef_pkg::ADR_FSB, i[7:0]);
			cyc(5);
			chk({compositeOn, lumaChromaOn}, i[1:0]);
		end
		// two-wire port
		@(posedge core_clk) ifaceSelect <= 1'b0;
		cyc(10);
		chk(serialOutEn, 1'b0);
		host_i.i2cStart;
		host_i.i2cByte(8'h00, got, ack);
		host_i.i2cStop;
		chk(ack, 1'b0);
		host_i.i2cStart;
		host_i.i2cByte(8'h8c, got, ack);
		host_i.i2cStop;
		chk(ack, 1'b0);
		@(posedge core_clk) saPin <= 1'b1;
		cyc(5);
		host_i.i2cStart;
		host_i.i2cByte(8'h8c, got, ack);
		host_i.i2cByte(8'h01, got, ack);
		host_i.i2cByte(8'h12, got, ack);
		host_i.i2cByte(8'h03, got, ack);
		host_i.i2cStop;
		chk(ack, 1'b1);
		host_i.i2cStart;
		host_i.i2cByte(8'h8d, got, ack);
		chk(ack, 1'b1);
		host_i.i2cByte(8'hff, got, ack);
		host_i.i2cStop;
		chk(got, ID_LO);
		@(posedge core_clk) ifaceSelect <= 1'b1;
		cyc(10);
		chk(serialOutEn, 1'b1);
		host_i.frame(8'h01, 32'h0, 2, rd);
		chk(rd[15:0], 16'h1203);
		report_and_stop;
	end
endmodule : video_encoder_control_frontend_tb_top
